// File: pkg/twi_mt_pkg.sv
package twi_mt_pkg;
   // register addresses on the plain software port
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_DATA = 2'h2;
   localparam logic [1:0] ADDR_BITRATE = 2'h3;
   // control register bit positions
   localparam int CTRL_FLAG = 7;
   localparam int CTRL_ACKEN = 6;
   localparam int CTRL_START = 5;
   localparam int CTRL_STOP = 4;
   localparam int CTRL_WCOL = 3;
   localparam int CTRL_ENABLE = 2;
   // status register: code in upper bits, prescaler in the low two
   localparam logic [7:0] STATUS_CODE_MASK = 8'hF8;
   localparam logic [7:0] ST_START = 8'h08;
   localparam logic [7:0] ST_RSTART = 8'h10;
   localparam logic [7:0] ST_ADDR_ACK = 8'h18;
   localparam logic [7:0] ST_ADDR_NACK = 8'h20;
   localparam logic [7:0] ST_DATA_ACK = 8'h28;
   localparam logic [7:0] ST_DATA_NACK = 8'h30;
   localparam logic [7:0] ST_ARB_LOST = 8'h38;
   localparam logic [7:0] ST_IDLE = 8'hF8;
   localparam logic [7:0] ST_MASTER_RX = 8'h40;
   localparam logic [7:0] BITRATE_RESET = 8'h10;
   // bus timing: bus must be seen idle this long before a start
   localparam int BUS_FREE_NS = 4700;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_WAIT_FREE = 4'b0001,
      S_START = 4'b0010,
      S_HOLD = 4'b0011,
      S_BIT_LOW = 4'b0100,
      S_BIT_HIGH = 4'b0101,
      S_STOP_LOW = 4'b0110,
      S_STOP_HIGH = 4'b0111,
      S_STOP_END = 4'b1000,
      S_RS_LOW = 4'b1001,
      S_RS_HIGH = 4'b1010
   } mt_state_t;
endpackage : twi_mt_pkg

// File: core/twi_master_tx.sv
module twi_master_tx #(
   parameter int HALF_BIT_MIN = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic master_rx_mode
);
   twi_mt_pkg::mt_state_t state_reg;
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic scl_filt_reg;
   logic sda_filt_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic bus_busy_reg;
   logic [12:0] free_cnt_reg;
   logic flag_reg;
   logic ack_enable_bit;
   logic start_req;
   logic stop_req;
   logic write_collision_bit;
   logic enable_reg;
   logic [7:0] serial_data_reg;
   logic [7:0] status_code_reg;
   logic [1:0] prescale_reg;
   logic [7:0] bitrate_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [8:0] tick_cnt_reg;
   logic addr_phase_reg;
   logic acked_reg;
   logic set_flag;
   logic [7:0] set_code;
   logic resume;
   logic tick;
   logic wr_ctrl;
   logic wr_data;
   logic start_cond;
   logic stop_cond;
   logic bus_free;
   logic drive_sda;
   logic [7:0] ctrl_view;

   assign wr_ctrl = reg_write && reg_addr == twi_mt_pkg::ADDR_CTRL;
   assign wr_data = reg_write && reg_addr == twi_mt_pkg::ADDR_DATA;
   // flag clear by writing one, enable must stay set
   assign resume = wr_ctrl && reg_wdata[twi_mt_pkg::CTRL_FLAG]
      && reg_wdata[twi_mt_pkg::CTRL_ENABLE];

   // three-stage sampling of the open-drain wires
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         scl_filt_reg <= 1'b1;
         sda_filt_reg <= 1'b1;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
         if (scl_sync_reg[1] == scl_sync_reg[2])
            scl_filt_reg <= scl_sync_reg[2];
         if (sda_sync_reg[1] == sda_sync_reg[2])
            sda_filt_reg <= sda_sync_reg[2];
      end
   end

   // start and stop conditions seen on the wires, from anyone
   assign start_cond = scl_filt_reg && sda_prev_reg && !sda_filt_reg;
   assign stop_cond = scl_filt_reg && !sda_prev_reg && sda_filt_reg;

   // bus busy tracking; free needs a quiet stretch after stop
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sda_prev_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         bus_busy_reg <= 1'b0;
         free_cnt_reg <= 13'h0000;
      end
      else
      begin
         sda_prev_reg <= sda_filt_reg;
         scl_prev_reg <= scl_filt_reg;
         if (start_cond)
            bus_busy_reg <= 1'b1;
         else if (stop_cond)
            bus_busy_reg <= 1'b0;
         if (!scl_filt_reg || !sda_filt_reg || start_cond)
            free_cnt_reg <= 13'h0000;
         else if (free_cnt_reg != 13'(twi_mt_pkg::BUS_FREE_CYC))
            free_cnt_reg <= free_cnt_reg + 13'h0001;
      end
   end
   assign bus_free = !bus_busy_reg && free_cnt_reg == 13'(twi_mt_pkg::BUS_FREE_CYC);

   // half-bit timer; bit rate register stretches it
   assign tick = tick_cnt_reg == 9'h000;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         tick_cnt_reg <= 9'h000;
      else if (tick || state_reg == twi_mt_pkg::S_HOLD || state_reg == twi_mt_pkg::S_IDLE)
         tick_cnt_reg <= 9'(bitrate_reg) + 9'(HALF_BIT_MIN);
      else
         tick_cnt_reg <= tick_cnt_reg - 9'h001;
   end

   // control bits; hardware set of the flag wins over a clear in the same cycle
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         flag_reg <= 1'b0;
         ack_enable_bit <= 1'b0;
         start_req <= 1'b0;
         stop_req <= 1'b0;
         enable_reg <= 1'b0;
         write_collision_bit <= 1'b0;
      end
      else
      begin
         if (set_flag)
            flag_reg <= 1'b1;
         else if (wr_ctrl && reg_wdata[twi_mt_pkg::CTRL_FLAG])
            flag_reg <= 1'b0;
         if (wr_ctrl)
         begin
            ack_enable_bit <= reg_wdata[twi_mt_pkg::CTRL_ACKEN]; // stored only
            start_req <= reg_wdata[twi_mt_pkg::CTRL_START];
            enable_reg <= reg_wdata[twi_mt_pkg::CTRL_ENABLE];
         end
         // stop bit drops itself once the stop has gone out
         if (state_reg == twi_mt_pkg::S_STOP_END && tick)
            stop_req <= 1'b0;
         else if (wr_ctrl)
            stop_req <= reg_wdata[twi_mt_pkg::CTRL_STOP];
         if (wr_data && !flag_reg)
            write_collision_bit <= 1'b1;
         else if (wr_data)
            write_collision_bit <= 1'b0;
      end
   end

   // data register takes writes only while the flag is high
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         serial_data_reg <= 8'hFF;
      else if (wr_data && flag_reg)
         serial_data_reg <= reg_wdata;
   end

   // status code and prescaler; code low bits are always zero
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         status_code_reg <= twi_mt_pkg::ST_IDLE;
         prescale_reg <= 2'h0;
         bitrate_reg <= twi_mt_pkg::BITRATE_RESET;
      end
      else
      begin
         if (set_flag)
            status_code_reg <= set_code & twi_mt_pkg::STATUS_CODE_MASK;
         else if (resume && state_reg == twi_mt_pkg::S_HOLD)
            status_code_reg <= twi_mt_pkg::ST_IDLE;
         if (reg_write && reg_addr == twi_mt_pkg::ADDR_STATUS)
            prescale_reg <= reg_wdata[1:0];
         if (reg_write && reg_addr == twi_mt_pkg::ADDR_BITRATE)
            bitrate_reg <= reg_wdata;
      end
   end

   // main sequencer: start, bytes, ack, stop, repeated start
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= twi_mt_pkg::S_IDLE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         addr_phase_reg <= 1'b0;
         acked_reg <= 1'b0;
         master_rx_mode <= 1'b0;
         scl_out <= 1'b1;
         drive_sda <= 1'b0;
         set_flag <= 1'b0;
         set_code <= twi_mt_pkg::ST_IDLE;
      end
      else
      begin
         set_flag <= 1'b0;
         case (state_reg)
            twi_mt_pkg::S_IDLE:
            begin
               scl_out <= 1'b1;
               drive_sda <= 1'b0;
               if (resume && reg_wdata[twi_mt_pkg::CTRL_START])
                  state_reg <= twi_mt_pkg::S_WAIT_FREE;
            end
            twi_mt_pkg::S_WAIT_FREE:
               if (bus_free && tick)
               begin
                  // a start after a free bus is never a repeated one
                  addr_phase_reg <= 1'b0;
                  drive_sda <= 1'b1;
                  state_reg <= twi_mt_pkg::S_START;
               end
            twi_mt_pkg::S_START:
               if (tick)
               begin
                  scl_out <= 1'b0;
                  set_flag <= 1'b1;
                  set_code <= addr_phase_reg ? twi_mt_pkg::ST_RSTART
                     : twi_mt_pkg::ST_START;
                  addr_phase_reg <= 1'b1;
                  state_reg <= twi_mt_pkg::S_HOLD;
               end
            // bus frozen until software clears the flag; scl held low except after lost arbitration
            twi_mt_pkg::S_HOLD:
               if (resume && !set_flag)
               begin
                  if (status_code_reg == twi_mt_pkg::ST_ARB_LOST)
                     state_reg <= reg_wdata[twi_mt_pkg::CTRL_START]
                        ? twi_mt_pkg::S_WAIT_FREE
                        : twi_mt_pkg::S_IDLE;
                  else if (reg_wdata[twi_mt_pkg::CTRL_STOP])
                  begin
                     drive_sda <= 1'b1;
                     state_reg <= twi_mt_pkg::S_STOP_LOW;
                  end
                  else if (reg_wdata[twi_mt_pkg::CTRL_START]
                     && status_code_reg != twi_mt_pkg::ST_START
                     && status_code_reg != twi_mt_pkg::ST_RSTART)
                  begin
                     drive_sda <= 1'b0;
                     state_reg <= twi_mt_pkg::S_RS_LOW;
                  end
                  else
                  begin
                     // address or data byte; ack enable ignored here
                     shift_reg <= serial_data_reg;
                     if (status_code_reg == twi_mt_pkg::ST_START
                        || status_code_reg == twi_mt_pkg::ST_RSTART)
                        master_rx_mode <= serial_data_reg[0];
                     else
                        addr_phase_reg <= 1'b0;
                     bit_cnt_reg <= 4'h0;
                     drive_sda <= !serial_data_reg[7];
                     state_reg <= twi_mt_pkg::S_BIT_LOW;
                  end
               end
            twi_mt_pkg::S_BIT_LOW:
               if (tick)
               begin
                  scl_out <= 1'b1;
                  state_reg <= twi_mt_pkg::S_BIT_HIGH;
               end
            twi_mt_pkg::S_BIT_HIGH:
               // wait out clock stretching by the slave
               if (tick && scl_filt_reg)
               begin
                  scl_out <= 1'b0;
                  if (bit_cnt_reg != 4'h8 && !drive_sda && !sda_filt_reg)
                  begin
                     // let go of both wires so the winner can finish its frame
                     scl_out <= 1'b1;
                     drive_sda <= 1'b0;
                     set_flag <= 1'b1;
                     set_code <= twi_mt_pkg::ST_ARB_LOST;
                     state_reg <= twi_mt_pkg::S_HOLD;
                  end
                  else if (bit_cnt_reg == 4'h8)
                  begin
                     acked_reg <= !sda_filt_reg;
                     set_flag <= 1'b1;
                     if (addr_phase_reg)
                        set_code <= sda_filt_reg ? twi_mt_pkg::ST_ADDR_NACK
                           : twi_mt_pkg::ST_ADDR_ACK;
                     else
                        set_code <= sda_filt_reg ? twi_mt_pkg::ST_DATA_NACK
                           : twi_mt_pkg::ST_DATA_ACK;
                     if (addr_phase_reg && master_rx_mode)
                        set_code <= twi_mt_pkg::ST_MASTER_RX;
                     state_reg <= twi_mt_pkg::S_HOLD;
                  end
                  else
                  begin
                     shift_reg <= {shift_reg[6:0], 1'b1};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     // last data bit done: release sda for the ack
                     drive_sda <= bit_cnt_reg == 4'h7 ? 1'b0 : !shift_reg[6];
                     state_reg <= twi_mt_pkg::S_BIT_LOW;
                  end
               end
            twi_mt_pkg::S_STOP_LOW:
               if (tick)
               begin
                  scl_out <= 1'b1;
                  state_reg <= twi_mt_pkg::S_STOP_HIGH;
               end
            twi_mt_pkg::S_STOP_HIGH:
               if (tick)
               begin
                  drive_sda <= 1'b0;
                  addr_phase_reg <= 1'b0;
                  state_reg <= twi_mt_pkg::S_STOP_END;
               end
            twi_mt_pkg::S_STOP_END:
               if (tick)
                  state_reg <= start_req ? twi_mt_pkg::S_WAIT_FREE
                     : twi_mt_pkg::S_IDLE;
            twi_mt_pkg::S_RS_LOW:
               if (tick)
               begin
                  scl_out <= 1'b1;
                  state_reg <= twi_mt_pkg::S_RS_HIGH;
               end
            twi_mt_pkg::S_RS_HIGH:
               if (tick)
               begin
                  drive_sda <= 1'b1;
                  addr_phase_reg <= 1'b1; // marks the start as repeated
                  state_reg <= twi_mt_pkg::S_START;
               end
            default:
               state_reg <= twi_mt_pkg::S_IDLE;
         endcase
      end
   end

   // open-drain drive: only pull low, lost bus releases both wires
   assign sda_out = 1'b0;
   assign sda_oe = drive_sda;
   assign scl_oe = !scl_out;

   assign ctrl_view = {flag_reg, ack_enable_bit, start_req, stop_req,
      write_collision_bit, enable_reg, 2'h0};

   // read data one cycle after the strobe; status shows masked code plus prescaler
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_read)
         case (reg_addr)
            twi_mt_pkg::ADDR_CTRL: reg_rdata <= ctrl_view;
            twi_mt_pkg::ADDR_STATUS: reg_rdata <= status_code_reg | {6'h00, prescale_reg};
            twi_mt_pkg::ADDR_DATA: reg_rdata <= serial_data_reg;
            twi_mt_pkg::ADDR_BITRATE: reg_rdata <= bitrate_reg;
            default: reg_rdata <= 8'h00;
         endcase
      else
         reg_rdata <= 8'h00;
   end
endmodule : twi_master_tx

// File: verification/twi_master_tx_props.sv
module twi_master_tx_props #(
   parameter int HALF_BIT_MIN = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic scl_in,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic master_rx_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   logic rd_ctrl_q, flag_seen, wcol_ok, clr_wr;
   logic [7:0] dat_q;
   logic [9:0] quiet_cnt, since_scl, low_cnt;
   assign clr_wr = reg_write && reg_addr == twi_mt_pkg::ADDR_CTRL && reg_wdata[7];
   // flag shadow learned from reads; only trusted while set, so it never over-claims
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         rd_ctrl_q <= 1'b0;
         flag_seen <= 1'b0;
      end
      else
      begin
         rd_ctrl_q <= reg_read && reg_addr == twi_mt_pkg::ADDR_CTRL;
         if (clr_wr)
            flag_seen <= 1'b0;
         else if (rd_ctrl_q && reg_rdata[twi_mt_pkg::CTRL_FLAG])
            flag_seen <= 1'b1;
      end
   // last data write taken while the flag was known set
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         wcol_ok <= 1'b0;
         dat_q <= 8'h00;
      end
      else if (reg_write && reg_addr == twi_mt_pkg::ADDR_DATA)
      begin
         wcol_ok <= flag_seen;
         if (flag_seen)
            dat_q <= reg_wdata;
      end
   // saturating counters of quiet bus, cycles since scl pulled, low phase length
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         quiet_cnt <= 10'h000;
         since_scl <= 10'h3ff;
         low_cnt <= 10'h000;
      end
      else
      begin
         quiet_cnt <= (scl_in && sda_in) ? quiet_cnt + 10'(quiet_cnt != 10'h3ff) : 10'h000;
         since_scl <= scl_oe ? 10'h000 : since_scl + 10'(since_scl != 10'h3ff);
         low_cnt <= scl_oe ? low_cnt + 10'(low_cnt != 10'h3ff) : 10'h000;
      end
   reset_quiet_a: assert property ($fell(rst) |-> !scl_oe && !sda_oe && !master_rx_mode)
      else $error("bus or mode not idle after reset");
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   start_free_a: assert property ($rose(sda_oe) && !scl_oe |->
      quiet_cnt >= twi_mt_pkg::BUS_FREE_CYC || since_scl < 10'd64)
      else $error("start issued on a busy bus");
   flag_hold_a: assert property (flag_seen && !clr_wr |=> $stable(scl_oe) && $stable(sda_oe))
      else $error("bus moved while flag set");
   flag_sticky_a: assert property (rd_ctrl_q && flag_seen |-> reg_rdata[7])
      else $error("flag dropped without a clearing write");
   wcol_clear_a: assert property (rd_ctrl_q && wcol_ok |-> !reg_rdata[3])
      else $error("collision bit set after accepted data write");
   rx_mode_dir_a: assert property ($rose(master_rx_mode) |-> dat_q[0])
      else $error("receiver mode without read direction");
   scl_low_min_a: assert property ($fell(scl_oe) |-> low_cnt > HALF_BIT_MIN)
      else $error("clock low phase shorter than half bit");
endmodule : twi_master_tx_props

bind twi_master_tx twi_master_tx_props #(.HALF_BIT_MIN(HALF_BIT_MIN)) u_twi_master_tx_props (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in),
   .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .master_rx_mode(master_rx_mode)
);

// File: verification/slave_rx_model.sv
module slave_rx_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   input wire logic lose_arb,
   output logic sda_pull,
   output logic [7:0] rx_byte,
   output int n_stop
);
   timeunit 1ns;
   timeprecision 1ns;
   int bit_cnt = 9;
   logic ack_phase = 1'b0;
   // start or repeated start rearms the receiver; 9 means not addressed
   // look a little later: data and clock move in the same step
   always @(negedge sda)
   begin
      #1;
      if (scl && !sda)
         bit_cnt = 0;
   end
   always @(posedge sda)
   begin
      #1;
      if (scl && sda)
      begin
         bit_cnt = 9;
         n_stop++;
      end
   end
   // bits sampled on the rising clock, msb first
   always @(posedge scl)
      if (bit_cnt < 8)
      begin
         rx_byte = {rx_byte[6:0], sda};
         bit_cnt++;
      end
   // acknowledge slot spans the ninth clock
   always @(negedge scl)
      if (bit_cnt == 8 && !ack_phase)
         ack_phase = 1'b1;
      else if (ack_phase)
      begin
         ack_phase = 1'b0;
         bit_cnt = 0;
      end
   // lose_arb mimics a rival master holding data low mid-byte
   assign sda_pull = (ack_phase && ack_en) || (lose_arb && bit_cnt < 8);
endmodule : slave_rx_model

// File: verification/i2c_master_transmitter_test.sv
module i2c_master_transmitter_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic ack_en = 1'b1;
   logic lose_arb = 1'b0;
   logic [7:0] reg_rdata, rx_byte, d;
   logic scl_out, scl_oe, sda_out, sda_oe, master_rx_mode, sda_pull;
   int n_errors = 0;
   int n_compared = 0;
   int n_stop;
   int seed = 32'hb70a_cca9;
   // pulled-up open-drain wires: any party pulling low wins
   wire logic scl = !scl_oe;
   wire logic sda = !(sda_oe || sda_pull);
   always #5 clk_sys = !clk_sys;
   twi_master_tx #(.HALF_BIT_MIN(4)) u_twi_master_tx (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .master_rx_mode(master_rx_mode)
   );
   slave_rx_model u_slave_rx_model (
      .scl(scl), .sda(sda), .ack_en(ack_en), .lose_arb(lose_arb), .sda_pull(sda_pull),
      .rx_byte(rx_byte), .n_stop(n_stop)
   );
   task automatic summarize;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // register port cycles: one strobe cycle each, read answer one cycle later
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // bounded poll; running out shows up as a mismatch
   task automatic wait_reg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] v);
      logic [7:0] c;
      c = ~v;
      for (int i = 0; i < 3000 && (c & m) !== v; i++)
         rd(a, c);
      chk("poll", v, c & m);
   endtask : wait_reg
   // codes are compared with the prescaler bits masked off
   task automatic st(input logic [7:0] code);
      logic [7:0] s;
      rd(twi_mt_pkg::ADDR_STATUS, s);
      chk("status", code, s & twi_mt_pkg::STATUS_CODE_MASK);
   endtask : st
   task automatic start(input logic [7:0] v, input logic [7:0] code);
      wr(twi_mt_pkg::ADDR_CTRL, v);
      wait_reg(twi_mt_pkg::ADDR_CTRL, 8'h80, 8'h80);
      st(code);
   endtask : start
   // ack enable bit is random: it must not matter to a transmitter
   task automatic send(input logic [7:0] b, input logic [7:0] code);
      wr(twi_mt_pkg::ADDR_DATA, b);
      wr(twi_mt_pkg::ADDR_CTRL, 8'h84 | (8'($random(seed)) & 8'h40));
      wait_reg(twi_mt_pkg::ADDR_CTRL, 8'h80, 8'h80);
      st(code);
      chk("slave byte", b, rx_byte);
   endtask : send
   task automatic lose(input logic [7:0] b);
      lose_arb <= 1'b1;
      wr(twi_mt_pkg::ADDR_DATA, b);
      wr(twi_mt_pkg::ADDR_CTRL, 8'h84);
      wait_reg(twi_mt_pkg::ADDR_CTRL, 8'h80, 8'h80);
      st(twi_mt_pkg::ST_ARB_LOST);
      chk("bus drive", 8'h00, {6'h00, scl_oe, sda_oe});
      // the rival ends its frame with a stop while the clock is released
      lose_arb <= 1'b0;
   endtask : lose
   function automatic logic [7:0] data_code(input logic ack);
      return ack ? twi_mt_pkg::ST_DATA_ACK : twi_mt_pkg::ST_DATA_NACK;
   endfunction : data_code
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rd(twi_mt_pkg::ADDR_BITRATE, d);
      chk("bitrate", twi_mt_pkg::BITRATE_RESET, d);
      st(twi_mt_pkg::ST_IDLE);
      wr(twi_mt_pkg::ADDR_BITRATE, 8'h03); // half bit 8 cycles, 160 ns bit
      wr(twi_mt_pkg::ADDR_DATA, 8'h5a);
      rd(twi_mt_pkg::ADDR_CTRL, d);
      chk("collision", 8'h08, d & 8'h08);
      start(8'ha4, twi_mt_pkg::ST_START);
      wr(twi_mt_pkg::ADDR_CTRL, 8'h04);
      rd(twi_mt_pkg::ADDR_CTRL, d);
      chk("flag", 8'h80, d & 8'h80);
      send({7'($random(seed)), 1'b0}, twi_mt_pkg::ST_ADDR_ACK);
      chk("rx mode", 8'h00, {7'h00, master_rx_mode});
      repeat (4)
      begin
         ack_en <= 1'($random(seed));
         @(posedge clk_sys);
         send(8'($random(seed)), data_code(ack_en));
      end
      ack_en <= 1'b1;
      start(8'ha4, twi_mt_pkg::ST_RSTART);
      ack_en <= 1'b0;
      send({7'($random(seed)), 1'b0}, twi_mt_pkg::ST_ADDR_NACK);
      ack_en <= 1'b1;
      send(8'($random(seed)), twi_mt_pkg::ST_DATA_ACK);
      start(8'hb4, twi_mt_pkg::ST_START);
      rd(twi_mt_pkg::ADDR_CTRL, d);
      chk("stop bit", 8'h00, d & 8'h10);
      send({7'($random(seed)), 1'b0}, twi_mt_pkg::ST_ADDR_ACK);
      d = 8'(n_stop);
      wr(twi_mt_pkg::ADDR_CTRL, 8'h94);
      wait_reg(twi_mt_pkg::ADDR_STATUS, 8'hf8, 8'hf8);
      wait_reg(twi_mt_pkg::ADDR_CTRL, 8'h10, 8'h00);
      chk("stops", d + 8'h01, 8'(n_stop));
      rd(twi_mt_pkg::ADDR_CTRL, d);
      chk("stop bit", 8'h00, d & 8'h10);
      start(8'ha4, twi_mt_pkg::ST_START);
      lose({1'b1, 6'($random(seed)), 1'b0});
      wr(twi_mt_pkg::ADDR_CTRL, 8'h84);
      wait_reg(twi_mt_pkg::ADDR_STATUS, 8'hf8, 8'hf8);
      chk("bus release", 8'h00, {6'h00, scl_oe, sda_oe});
      start(8'ha4, twi_mt_pkg::ST_START);
      lose(8'hff);
      start(8'ha4, twi_mt_pkg::ST_START);
      send({7'($random(seed)), 1'b0}, twi_mt_pkg::ST_ADDR_ACK);
      start(8'ha4, twi_mt_pkg::ST_RSTART);
      send({7'($random(seed)), 1'b1}, twi_mt_pkg::ST_MASTER_RX);
      chk("rx mode", 8'h01, {7'h00, master_rx_mode});
      // reset in mid-run drops the mode
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1 chk("rx mode", 8'h00, {7'h00, master_rx_mode});
      summarize();
   end
   // watchdog: 90k cycles, several times what the sequence needs
   initial
   begin
      #900_000;
      n_errors++;
      summarize();
   end
endmodule : i2c_master_transmitter_test
